// *** design/wol_detector.sv ***
// wake-on-network detector: magic packet, custom crc packets, link change
// assumes: rx bytes and link state come from logic on aclk; registers over axi4-lite
//
// Overview of operation
// - six 0xFF bytes then sixteen local MAC copies is a magic packet.
// - magic matching only while its enable bit is one, using stored MAC.
// - magic detection is readable in a receive status register.
// - only mask-selected bytes of the first 64 feed each CRC.
// - at frame end, CRC equal to expected value raises power event.
// - four custom filters, enabled by wake control bits 2 to 5.
// - each filter holds a 32-bit expected CRC in low and high halves.
// - each filter has four mask registers covering 64 frame bytes.
// - enabled link-up or link-down transitions raise the power event.
// - the causing link change is readable in interrupt status register.
// - after reset every wake source is disabled.
// - power event routes to indicator pin or irq pin by strap fields.
// - wake control output select decides each pin's function.
// - power event holds until software clears the source's enable bit.
// - power event pins are active low.
// - irq pin level inverts with the interrupt polarity invert bit.
// - standard registers are direct; wake configuration is indirect.
// - indirect space reached via control index 0xD and data index 0xE.
//
// Added by the designer: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "wol_params.svh"
module wol_detector
  import wol_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_last,
  input wire logic rx_error,
  input wire logic link_up,
  output logic power_event_on_led_pin_n,
  output logic power_event_on_irq_pin_n
);
  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [15:0] mmd_q [`WOL_MMD_DEPTH];
  logic [15:0] mmd_ctrl_q;
  logic [5:0] mmd_addr_q;
  logic [15:0] control_q;
  logic [7:0] wake_flags_q;
  logic [15:0] wake_ctrl;
  logic [47:0] mac;
  logic wr_take;
  logic rd_take;
  logic [4:0] wr_idx;
  logic [4:0] rd_idx;
  logic wr_hit;
  logic mmd_wr;
  logic mmd_rd;
  logic [15:0] wr_val;

  assign wake_ctrl = mmd_q[`WOL_MMD_WAKE_CTRL];
  assign mac = {mmd_q[`WOL_MMD_MAC_HI], mmd_q[`WOL_MMD_MAC_MI], mmd_q[`WOL_MMD_MAC_LO]};
  assign wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign rd_take = s_axi_arvalid && s_axi_arready;
  assign wr_idx = s_axi_awaddr[6:2];
  assign rd_idx = s_axi_araddr[6:2];
  assign wr_val = {s_axi_wstrb[1] ? s_axi_wdata[15:8] : 8'h00,
                   s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00};
  assign wr_hit = (s_axi_awaddr[7] == 1'b0) && (s_axi_awaddr[1:0] == 2'b00) &&
                  (wr_idx == `WOL_IDX_MMD_CTRL || wr_idx == `WOL_IDX_MMD_DATA ||
                   wr_idx == `WOL_IDX_CONTROL);
  assign mmd_wr = wr_take && wr_hit && wr_idx == `WOL_IDX_MMD_DATA &&
                  mmd_ctrl_q[15:14] != `WOL_FN_ADDR;
  assign mmd_rd = rd_take && s_axi_araddr[7] == 1'b0 && rd_idx == `WOL_IDX_MMD_DATA &&
                  mmd_ctrl_q[15:14] != `WOL_FN_ADDR;

  // ----------------------------------------------------------------
  // axi4-lite handshakes
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `WOL_RESP_OKAY;
    end else if (wr_take) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? `WOL_RESP_OKAY : `WOL_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  function automatic logic [15:0] mmd_read(input logic [5:0] a);
    logic [15:0] v;
    v = 16'h0000;
    if (mmd_ctrl_q[4:0] != `WOL_MMD_DEVAD || a >= 6'(`WOL_MMD_DEPTH)) begin
      v = 16'h0000;
    end else if (a == `WOL_MMD_MAGIC_STAT) begin
      v = {15'h0000, wake_flags_q[`WOL_WC_MAGIC]};
    end else begin
      v = mmd_q[a];
    end
    return v;
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `WOL_RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `WOL_RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      if (s_axi_araddr[7] || s_axi_araddr[1:0] != 2'b00) begin
        s_axi_rresp <= `WOL_RESP_SLVERR;
      end else if (rd_idx == `WOL_IDX_MMD_CTRL) begin
        s_axi_rdata <= {16'h0000, mmd_ctrl_q};
      end else if (rd_idx == `WOL_IDX_MMD_DATA) begin
        s_axi_rdata <= {16'h0000, mmd_ctrl_q[15:14] == `WOL_FN_ADDR ?
                        {10'h000, mmd_addr_q} : mmd_read(mmd_addr_q)};
      end else if (rd_idx == `WOL_IDX_IRQ_STAT) begin
        s_axi_rdata[`WOL_IRQ_LINK_UP] <= wake_flags_q[`WOL_WC_LINK_UP];
        s_axi_rdata[`WOL_IRQ_LINK_DOWN] <= wake_flags_q[`WOL_WC_LINK_DOWN];
      end else if (rd_idx == `WOL_IDX_CONTROL) begin
        s_axi_rdata <= {16'h0000, control_q};
      end else begin
        s_axi_rresp <= `WOL_RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // direct registers and indirect pointer
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mmd_ctrl_q <= 16'h0000;
      control_q <= 16'h0000;
      mmd_addr_q <= 6'h00;
    end else begin
      if (wr_take && wr_hit && wr_idx == `WOL_IDX_MMD_CTRL) begin
        mmd_ctrl_q <= wr_val;
      end
      if (wr_take && wr_hit && wr_idx == `WOL_IDX_CONTROL) begin
        control_q <= wr_val;
      end
      if (wr_take && wr_hit && wr_idx == `WOL_IDX_MMD_DATA &&
          mmd_ctrl_q[15:14] == `WOL_FN_ADDR) begin
        mmd_addr_q <= wr_val[5:0];
      end else if ((mmd_wr || mmd_rd) && mmd_ctrl_q[15:14] == `WOL_FN_POSTINC) begin
        mmd_addr_q <= mmd_addr_q + 6'h01;
      end
    end
  end

  // reserved and read-only slots ignore writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < `WOL_MMD_DEPTH; i++) begin
        mmd_q[i] <= 16'h0000;
      end
    end else if (mmd_wr && mmd_ctrl_q[4:0] == `WOL_MMD_DEVAD &&
                 mmd_addr_q < 6'(`WOL_MMD_DEPTH) && mmd_addr_q != `WOL_MMD_MAGIC_STAT) begin
      mmd_q[mmd_addr_q] <= wr_val;
    end
  end

  // ----------------------------------------------------------------
  // frame position
  // ----------------------------------------------------------------
  logic [6:0] byte_idx_q;
  logic frame_ok;

  assign frame_ok = rx_valid && rx_last && !rx_error;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      byte_idx_q <= 7'h00;
    end else if (rx_valid) begin
      byte_idx_q <= rx_last ? 7'h00 :
                    (byte_idx_q == `WOL_FILTER_BYTES ? byte_idx_q : byte_idx_q + 7'h01);
    end
  end

  // ----------------------------------------------------------------
  // magic packet search
  // ----------------------------------------------------------------
  wol_magic_st_t mg_q;
  logic [2:0] ff_cnt_q;
  logic [6:0] mac_pos_q;
  logic [2:0] mac_byte_q;
  logic [7:0] mac_expect;
  logic magic_hit;

  always_comb begin
    mac_expect = 8'h00;
    for (int k = 0; k < 6; k++) begin
      if (mac_byte_q == 3'(k)) begin
        mac_expect = mac[47 - 8 * k -: 8];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mg_q <= WOL_MG_HUNT;
      ff_cnt_q <= 3'd0;
      mac_pos_q <= 7'h00;
      mac_byte_q <= 3'd0;
    end else if (rx_valid && rx_last) begin
      mg_q <= WOL_MG_HUNT;
      ff_cnt_q <= 3'd0;
      mac_pos_q <= 7'h00;
      mac_byte_q <= 3'd0;
    end else if (rx_valid) begin
      case (mg_q)
        WOL_MG_HUNT: begin
          if (ff_cnt_q == `WOL_SYNC_BYTES && rx_data == mac[47:40]) begin
            mg_q <= WOL_MG_MATCH;
            mac_pos_q <= 7'h01;
            mac_byte_q <= 3'd1;
          end else if (rx_data == `WOL_SYNC_BYTE) begin
            ff_cnt_q <= ff_cnt_q == `WOL_SYNC_BYTES ? ff_cnt_q : ff_cnt_q + 3'd1;
          end else begin
            ff_cnt_q <= 3'd0;
          end
        end
        WOL_MG_MATCH: begin
          if (rx_data == mac_expect) begin
            mac_pos_q <= mac_pos_q + 7'h01;
            mac_byte_q <= mac_byte_q == 3'd5 ? 3'd0 : mac_byte_q + 3'd1;
            if (mac_pos_q + 7'h01 == `WOL_MAC_BYTES) begin
              mg_q <= WOL_MG_FOUND;
            end
          end else begin
            mg_q <= WOL_MG_HUNT;
            ff_cnt_q <= rx_data == `WOL_SYNC_BYTE ? 3'd1 : 3'd0;
          end
        end
        WOL_MG_FOUND: begin
          mg_q <= WOL_MG_FOUND;
        end
        default: begin
          mg_q <= WOL_MG_HUNT;
        end
      endcase
    end
  end

  assign magic_hit = frame_ok && mg_q == WOL_MG_FOUND;

  // ----------------------------------------------------------------
  // custom packet filters
  // ----------------------------------------------------------------
  wol_stream_if st ();
  logic [3:0] custom_hit;

  assign st.start = rx_valid && rx_last;
  assign st.take = rx_valid && !rx_last && byte_idx_q < `WOL_FILTER_BYTES;
  assign st.idx = byte_idx_q[5:0];
  assign st.data = rx_data;
  assign st.done = frame_ok;

  for (genvar f = 0; f < `WOL_NUM_FILTERS; f++) begin : g_filter
    wol_crc_unit u_crc (
      .aclk(aclk),
      .aresetn(aresetn),
      .st(st),
      .mask({mmd_q[`WOL_MMD_MASK_BASE + 4 * f + 3], mmd_q[`WOL_MMD_MASK_BASE + 4 * f + 2],
             mmd_q[`WOL_MMD_MASK_BASE + 4 * f + 1], mmd_q[`WOL_MMD_MASK_BASE + 4 * f]}),
      .expected({mmd_q[`WOL_MMD_CRC_BASE + 2 * f + 1], mmd_q[`WOL_MMD_CRC_BASE + 2 * f]}),
      .hit(custom_hit[f])
    );
  end

  // ----------------------------------------------------------------
  // link change and sticky wake flags
  // ----------------------------------------------------------------
  logic link_prev_q;
  logic [7:0] wake_set;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_prev_q <= 1'b0;
    end else begin
      link_prev_q <= link_up;
    end
  end

  assign wake_set = {1'b0, magic_hit, custom_hit,
                     link_prev_q && !link_up, !link_prev_q && link_up};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_flags_q <= 8'h00;
    end else begin
      wake_flags_q <= (wake_flags_q | wake_set) & wake_ctrl[7:0];
    end
  end

  // ----------------------------------------------------------------
  // power event pins
  // ----------------------------------------------------------------
  logic pkt_evt;
  logic link_evt;
  logic led_evt;
  logic irq_evt;
  wol_osel_t osel;

  assign pkt_evt = |wake_flags_q[`WOL_WC_MAGIC:`WOL_WC_CUSTOM_LSB];
  assign link_evt = wake_flags_q[`WOL_WC_LINK_UP] || wake_flags_q[`WOL_WC_LINK_DOWN];
  assign osel = wol_osel_t'(wake_ctrl[`WOL_WC_OSEL_LSB +: 2]);

  always_comb begin
    case (osel)
      WOL_OSEL_PKT_LINK: begin
        led_evt = pkt_evt;
        irq_evt = link_evt;
      end
      WOL_OSEL_LINK_PKT: begin
        led_evt = link_evt;
        irq_evt = pkt_evt;
      end
      default: begin
        led_evt = pkt_evt || link_evt;
        irq_evt = pkt_evt || link_evt;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      power_event_on_led_pin_n <= 1'b1;
      power_event_on_irq_pin_n <= 1'b1;
    end else begin
      power_event_on_led_pin_n <= !(led_evt && mmd_q[`WOL_MMD_STRAP][`WOL_STRAP_LED_EN]);
      power_event_on_irq_pin_n <= !(irq_evt && mmd_q[`WOL_MMD_STRAP][`WOL_STRAP_IRQ_EN])
                                  ^ control_q[`WOL_CTRL_IRQ_INV];
    end
  end
endmodule

// *** shared/wol_params.svh ***
// offsets, field positions, reset values and counts of the wake-on-network detector
// assumes: included by the package and the design files by bare name
`ifndef WOL_PARAMS_SVH
`define WOL_PARAMS_SVH

// ----------------------------------------------------------------
// standard register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define WOL_IDX_MMD_CTRL 5'h0D
`define WOL_IDX_MMD_DATA 5'h0E
`define WOL_IDX_IRQ_STAT 5'h1B
`define WOL_IDX_CONTROL 5'h1F
`define WOL_AXI_AW 8

// ----------------------------------------------------------------
// indirect register space
// ----------------------------------------------------------------
`define WOL_MMD_DEVAD 5'h02
`define WOL_MMD_DEPTH 48
`define WOL_MMD_STRAP 6'h02
`define WOL_MMD_WAKE_CTRL 6'h10
`define WOL_MMD_MAC_LO 6'h11
`define WOL_MMD_MAC_MI 6'h12
`define WOL_MMD_MAC_HI 6'h13
`define WOL_MMD_CRC_BASE 6'h14
`define WOL_MMD_MASK_BASE 6'h1C
`define WOL_MMD_MAGIC_STAT 6'h2C

// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define WOL_WC_LINK_UP 0
`define WOL_WC_LINK_DOWN 1
`define WOL_WC_CUSTOM_LSB 2
`define WOL_WC_MAGIC 6
`define WOL_WC_OSEL_LSB 14
`define WOL_STRAP_LED_EN 8
`define WOL_STRAP_IRQ_EN 9
`define WOL_CTRL_IRQ_INV 14
`define WOL_IRQ_LINK_UP 0
`define WOL_IRQ_LINK_DOWN 2
`define WOL_FN_ADDR 2'b00
`define WOL_FN_POSTINC 2'b10

// ----------------------------------------------------------------
// frame figures and crc
// ----------------------------------------------------------------
`define WOL_SYNC_BYTES 3'd6
`define WOL_MAC_COPIES 16
`define WOL_MAC_BYTES 7'd96
`define WOL_FILTER_BYTES 7'd64
`define WOL_NUM_FILTERS 4
`define WOL_SYNC_BYTE 8'hFF
`define WOL_CRC_POLY 32'hEDB8_8320
`define WOL_CRC_INIT 32'hFFFF_FFFF
`define WOL_RESP_OKAY 2'b00
`define WOL_RESP_SLVERR 2'b10

`endif

// *** shared/wol_pkg.sv ***
// types of the wake-on-network detector
// assumes: wol_params.svh on the include path
package wol_pkg;
  `include "wol_params.svh"

  // magic packet search states
  typedef enum logic [2:0] {
    WOL_MG_HUNT  = 3'b001,
    WOL_MG_MATCH = 3'b010,
    WOL_MG_FOUND = 3'b100
  } wol_magic_st_t;

  // what each power event pin shows
  typedef enum logic [1:0] {
    WOL_OSEL_BOTH     = 2'b00,
    WOL_OSEL_PKT_LINK = 2'b01,
    WOL_OSEL_LINK_PKT = 2'b10,
    WOL_OSEL_ALL      = 2'b11
  } wol_osel_t;
endpackage

// *** shared/wol_stream_if.sv ***
// received byte stream shared by the custom packet crc units
// assumes: one clock, driven by the detector top
`timescale 1ns/100ps
interface wol_stream_if;
  logic start;
  logic take;
  logic [5:0] idx;
  logic [7:0] data;
  logic done;

  modport src (output start, output take, output idx, output data, output done);
  modport sink (input start, input take, input idx, input data, input done);
endinterface

// *** design/wol_crc_unit.sv ***
// one custom packet filter: crc over mask-selected bytes, compare at frame end
// assumes: stream from the detector top, same clock and reset
`timescale 1ns/100ps
`include "wol_params.svh"
module wol_crc_unit
  import wol_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  wol_stream_if.sink st,
  input wire logic [63:0] mask,
  input wire logic [31:0] expected,
  output logic hit
);
  logic [31:0] crc_q;
  logic [31:0] crc_d;

  // reflected byte-wise crc step
  always_comb begin
    crc_d = crc_q ^ {24'h00_0000, st.data};
    for (int b = 0; b < 8; b++) begin
      crc_d = crc_d[0] ? ((crc_d >> 1) ^ `WOL_CRC_POLY) : (crc_d >> 1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || st.start) begin
      crc_q <= `WOL_CRC_INIT;
    end else if (st.take && mask[st.idx]) begin
      crc_q <= crc_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hit <= 1'b0;
    end else begin
      hit <= st.done && (~crc_q == expected);
    end
  end
endmodule

// *** testbench/wol_frame_src.sv ***
// remote station model: plays queued frame bytes into the rx side
// assumes: one byte per aclk while a frame lasts, idle between frames
`timescale 1ns/100ps
module wol_frame_src (
  input wire logic aclk,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_last,
  output logic rx_error
);
  logic [7:0] q [$];
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_last = 1'b0;
    rx_error = 1'b0;
  end
  task automatic send(input logic err);
    while (q.size() > 0) begin
      @(posedge aclk);
      rx_valid <= 1'b1;
      rx_data <= q.pop_front();
      rx_last <= q.size() == 0;
      rx_error <= err && q.size() == 0;
    end
    @(posedge aclk);
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    rx_error <= 1'b0;
    rx_data <= ~rx_data;
  endtask
endmodule

// *** testbench/wol_detector_assertions.sv ***
// checker: bus timing and power event pins at the detector ports
// assumes: bound into every wol_detector instance, single clock
`timescale 1ns/100ps
module wol_detector_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rx_valid,
  input wire logic rx_last,
  input wire logic link_up,
  input wire logic power_event_on_led_pin_n,
  input wire logic power_event_on_irq_pin_n
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ------------------------------------------------
  // cycles since a frame end, link move or write
  // ------------------------------------------------
  logic [3:0] gap_q;
  logic link_q;
  always_ff @(posedge aclk) begin
    link_q <= link_up;
    if (!aresetn) gap_q <= 4'hF;
    else if ((rx_valid && rx_last) || link_up != link_q || s_axi_awready) gap_q <= 4'h0;
    else if (gap_q != 4'hF) gap_q <= gap_q + 4'h1;
  end
  // ------------------------------------------------
  // assertions
  // ------------------------------------------------
  a_reset_pins: assert property (disable iff (1'b0) !aresetn |=>
    power_event_on_led_pin_n && power_event_on_irq_pin_n) else $error("pin low after reset");
  a_aw_pair: assert property (s_axi_awready == s_axi_wready)
    else $error("awready and wready split");
  a_aw_cause: assert property (s_axi_awready |->
    $past(s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid)) else $error("awready unasked");
  a_b_follow: assert property (s_axi_awready |=> s_axi_bvalid)
    else $error("no write response");
  a_r_follow: assert property (s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("no read response");
  a_b_stand: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_r_stand: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  a_led_cause: assert property ($fell(power_event_on_led_pin_n) |-> gap_q <= 4'h7)
    else $error("led pin fell without cause");
  a_irq_cause: assert property ($fell(power_event_on_irq_pin_n) |-> gap_q <= 4'h7)
    else $error("irq pin fell without cause");
  a_pin_release: assert property ($rose(power_event_on_led_pin_n) ||
    $rose(power_event_on_irq_pin_n) |-> $past(s_axi_awready, 2) || $past(s_axi_awready, 3)
    || $past(s_axi_awready, 4)) else $error("pin released without write");
  c_led_wake: cover property ($fell(power_event_on_led_pin_n));
  c_irq_wake: cover property ($fell(power_event_on_irq_pin_n));
  c_b_wait: cover property (s_axi_bvalid && !s_axi_bready);
endmodule

bind wol_detector wol_detector_assertions u_wol_detector_assertions (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_wvalid, .s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .rx_valid,
  .rx_last, .link_up, .power_event_on_led_pin_n, .power_event_on_irq_pin_n);

// *** testbench/wol_detector_tb_top.sv ***
// bench: registers, frames and link moves checked against a pin model
// assumes: wol_frame_src plays frames; aclk at 125 MHz
`timescale 1ns/100ps
`include "wol_params.svh"
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin errors++; \
  $display("MISMATCH %s exp %h got %h", n, e, a); end end
module wol_detector_tb_top import wol_pkg::*;;
  logic aclk = 0, aresetn = 0, link_up = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, rx_data;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, v;
  logic [3:0] s_axi_wstrb = 4'hF, f_cu = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic rx_valid, rx_last, rx_error, power_event_on_led_pin_n, power_event_on_irq_pin_n;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [15:0] wc = 0, strap = 0;
  logic inv = 0, f_mg = 0, f_lu = 0, f_ld = 0;
  logic [47:0] mac;
  logic [63:0] msk;
  logic [7:0] frm [64];
  int errors = 0, checks_done = 0, cyc = 0;
  localparam logic [7:0] ad_ctl = {1'b0, `WOL_IDX_MMD_CTRL, 2'b00};
  localparam logic [7:0] ad_dat = {1'b0, `WOL_IDX_MMD_DATA, 2'b00};
  localparam logic [7:0] ad_irq = {1'b0, `WOL_IDX_IRQ_STAT, 2'b00};
  localparam logic [7:0] ad_con = {1'b0, `WOL_IDX_CONTROL, 2'b00};

  wol_detector u_wol_detector (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .rx_valid, .rx_data, .rx_last, .rx_error, .link_up,
    .power_event_on_led_pin_n, .power_event_on_irq_pin_n);
  wol_frame_src u_wol_frame_src (.aclk, .rx_valid, .rx_data, .rx_last, .rx_error);

  always #4 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'($urandom);
    @(posedge aclk);
    while (s_axi_awready !== 1'b1) @(posedge aclk);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    @(posedge aclk);
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    if (s_axi_bready !== 1'b1) begin
      s_axi_bready <= 1'b1;
      @(posedge aclk);
    end
    s_axi_bready <= 1'b0;
    `CHK("bresp", `WOL_RESP_OKAY, s_axi_bresp)
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    @(posedge aclk);
    while (s_axi_arready !== 1'b1) @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    @(posedge aclk);
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    e = s_axi_rresp;
  endtask

  task automatic sel(input logic [5:0] i, input logic [1:0] f);
    axi_wr(ad_ctl, {27'h0, `WOL_MMD_DEVAD});
    axi_wr(ad_dat, {26'h0, i});
    axi_wr(ad_ctl, {16'h0000, f, 9'h0, `WOL_MMD_DEVAD});
  endtask

  task automatic mw(input logic [5:0] i, input logic [15:0] d);
    sel(i, 2'b01);
    axi_wr(ad_dat, {16'h0000, d});
    if (i == `WOL_MMD_STRAP) strap = d;
    if (i == `WOL_MMD_WAKE_CTRL) begin
      wc = d;
      f_mg &= d[6];
      f_cu &= d[5:2];
      f_lu &= d[0];
      f_ld &= d[1];
    end
  endtask

  task automatic pins();
    logic pk, lk, l, q;
    repeat (5) @(posedge aclk);
    pk = f_mg | (|f_cu);
    lk = f_lu | f_ld;
    l = wc[15:14] == 2'b10 ? lk : wc[15:14] == 2'b01 ? pk : pk | lk;
    q = wc[15:14] == 2'b10 ? pk : wc[15:14] == 2'b01 ? lk : pk | lk;
    `CHK("led", ~(strap[8] & l), power_event_on_led_pin_n)
    `CHK("irq", ~(strap[9] & q) ^ inv, power_event_on_irq_pin_n)
  endtask

  task automatic magic(input logic bad, input logic err);
    u_wol_frame_src.q.push_back(8'($urandom));
    repeat (6) u_wol_frame_src.q.push_back(`WOL_SYNC_BYTE);
    for (int c = 0; c < 16; c++)
      for (int j = 0; j < 6; j++)
        u_wol_frame_src.q.push_back(mac[47 - 8 * j -: 8] ^ {7'h0, bad && c == 7});
    u_wol_frame_src.q.push_back(8'($urandom));
    u_wol_frame_src.send(err);
    if (!bad && !err) f_mg = wc[6];
  endtask

  function automatic logic [31:0] crc_of();
    logic [31:0] c;
    c = `WOL_CRC_INIT;
    for (int i = 0; i < 64; i++) begin
      if (msk[i]) begin
        c = c ^ {24'h00_0000, frm[i]};
        for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ `WOL_CRC_POLY : c >> 1;
      end
    end
    return ~c;
  endfunction

  initial begin
    v = $urandom(32'h0000_ebe9);
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    pins();
    sel(`WOL_MMD_WAKE_CTRL, 2'b01);
    axi_rd(ad_dat, v, r);
    `CHK("wake_ctrl", 32'h0000_0000, v)
    mac = 48'({$urandom(), $urandom()});
    mw(`WOL_MMD_MAC_HI, mac[47:32]);
    mw(`WOL_MMD_MAC_MI, mac[31:16]);
    mw(`WOL_MMD_MAC_LO, mac[15:0]);
    mw(`WOL_MMD_STRAP, 16'h0300);
    magic(1'b0, 1'b0);
    pins();
    mw(`WOL_MMD_WAKE_CTRL, 16'h0040);
    magic(1'b1, 1'b0);
    pins();
    magic(1'b0, 1'b1);
    pins();
    magic(1'b0, 1'b0);
    pins();
    sel(`WOL_MMD_MAGIC_STAT, 2'b01);
    axi_rd(ad_dat, v, r);
    `CHK("magic_stat", 1'b1, v[0])
    mw(`WOL_MMD_STRAP, 16'h0200);
    pins();
    mw(`WOL_MMD_STRAP, 16'h0300);
    mw(`WOL_MMD_WAKE_CTRL, 16'h0000);
    pins();
    for (int f = 0; f < 4; f++) begin
      foreach (frm[i]) frm[i] = 8'($urandom);
      msk = f == 0 ? '1 : f == 3 ? 64'h8000_0000_0000_0000 : {$urandom(), $urandom()};
      sel(6'(`WOL_MMD_MASK_BASE + 4 * f), `WOL_FN_POSTINC);
      for (int q = 0; q < 4; q++) axi_wr(ad_dat, {16'h0000, msk[16 * q +: 16]});
      for (int k = 0; k < 2; k++) begin
        v = crc_of() ^ 32'(k == 0);
        sel(6'(`WOL_MMD_CRC_BASE + 2 * f), `WOL_FN_POSTINC);
        axi_wr(ad_dat, {16'h0000, v[15:0]});
        axi_wr(ad_dat, {16'h0000, v[31:16]});
        if (k == 0) mw(`WOL_MMD_WAKE_CTRL, {2'(f), 8'h00, 6'(4 << f)});
        foreach (frm[i]) u_wol_frame_src.q.push_back(frm[i]);
        u_wol_frame_src.q.push_back(8'($urandom));
        u_wol_frame_src.send(1'b0);
        f_cu[f] = k == 1 && wc[2 + f];
        pins();
      end
      mw(`WOL_MMD_WAKE_CTRL, 16'h0000);
      pins();
    end
    mw(`WOL_MMD_WAKE_CTRL, 16'h4001);
    @(posedge aclk);
    link_up <= 1'b1;
    f_lu = wc[0];
    pins();
    axi_rd(ad_irq, v, r);
    `CHK("link_up_flag", 1'b1, v[0])
    axi_wr(ad_con, 32'h0000_4000);
    inv = 1'b1;
    pins();
    axi_wr(ad_con, 32'h0000_0000);
    inv = 1'b0;
    mw(`WOL_MMD_WAKE_CTRL, 16'h0002);
    pins();
    @(posedge aclk);
    link_up <= 1'b0;
    f_ld = wc[1];
    pins();
    axi_rd(ad_irq, v, r);
    `CHK("link_down_flag", 1'b1, v[2])
    mw(`WOL_MMD_WAKE_CTRL, 16'h0000);
    pins();
    axi_rd(8'h00, v, r);
    `CHK("unmapped_resp", `WOL_RESP_SLVERR, r)
    end_of_test();
  end
endmodule
